/* File: adcscp_cfg.svh */
`ifndef ADCSCP_CFG_SVH
`define ADCSCP_CFG_SVH

`define ADCSCP_ADDR_W 5
`define ADCSCP_DATA_W 11
`define ADCSCP_WORD_BITS 16
`define ADCSCP_NUM_REGS 8
`define ADCSCP_LAST_BIT 4'hF

`define ADCSCP_OFF_PWR 5'h00
`define ADCSCP_OFF_CLKG 5'h04
`define ADCSCP_OFF_FMT 5'h0A
`define ADCSCP_OFF_USRL 5'h0B
`define ADCSCP_OFF_TRIM 5'h0C
`define ADCSCP_OFF_OVRD 5'h0D
`define ADCSCP_OFF_DRV 5'h10
`define ADCSCP_OFF_TERM 5'h11
`define ADCSCP_RST_VAL 11'h000

`define ADCSCP_B_SWRST 10
`define ADCSCP_B_REF 5
`define ADCSCP_B_PDG 0
`define ADCSCP_B_PDCH_HI 4
`define ADCSCP_B_PDCH_LO 1
`define ADCSCP_B_CLKG_HI 6
`define ADCSCP_B_CLKG_LO 2
`define ADCSCP_B_NFMT 9
`define ADCSCP_B_TEST_HI 7
`define ADCSCP_B_TEST_LO 5
`define ADCSCP_B_TRIM_HI 10
`define ADCSCP_B_TRIM_LO 8
`define ADCSCP_B_USRT 0
`define ADCSCP_B_OV_EN 10
`define ADCSCP_B_OV_BYTE 7
`define ADCSCP_B_OV_ORDER 6
`define ADCSCP_B_OV_BOOST 5
`define ADCSCP_B_OV_EDGE 4
`define ADCSCP_B_OV_FRAME 2
`define ADCSCP_B_OV_DDR 1
`define ADCSCP_B_OV_WIRE 0

`define ADCSCP_CLK_MHZ 40
`define ADCSCP_EFFECT_NS 100
`define ADCSCP_EFFECT_CYC ((`ADCSCP_EFFECT_NS * `ADCSCP_CLK_MHZ) / 1000)

`endif

/* File: adcscp_pkg.sv */
package adcscp_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1
    } adcscp_state_e;

    typedef enum logic [2:0] {
        TP_NORMAL = 3'h0,
        TP_ZEROS = 3'h1,
        TP_ONES = 3'h2,
        TP_TOGGLE = 3'h3,
        TP_UNUSED = 3'h4,
        TP_USER = 3'h5,
        TP_DESKEW = 3'h6,
        TP_SYNC = 3'h7
    } adcscp_test_e;

    typedef enum logic [1:0] {
        STRAP_GND = 2'h0,
        STRAP_3_6 = 2'h1,
        STRAP_5_6 = 2'h2,
        STRAP_FULL = 2'h3
    } adcscp_strap_e;

    typedef struct packed {
        logic global_pd;
        logic [3:0] chan_pd;
        logic ext_ref;
        logic [4:0] clk_gain;
        logic lsb_first;
        logic offset_binary;
        adcscp_test_e test_sel;
        logic [11:0] user_word;
        logic [2:0] trim_gain;
        logic byte_wise;
        logic boost_en;
        logic rise_capture;
        logic frame14;
        logic sdr_clk;
        logic two_wire;
        logic [10:0] drive;
        logic [10:0] term;
    } adcscp_ctrl_s;

endpackage : adcscp_pkg

/* File: adcscp_top.sv */
`timescale 1ns/1ps
`include "adcscp_cfg.svh"

// Summary of operation
// - Shift only while select is low
// - Sample data on each serial clock fall
// - Sixteenth fall commits word to register
// - Trailing partial word bits are dropped
// - Many words per select-low period
// - Five address bits, then eleven data
// - Software reset bit clears all, self-clears
// - Write takes effect within 100 ns
// - Any reset clears all register bits
// - Format strap sets bit order, format
// - Register 00 reset, reference, power-down
// - Register 0A format and test select
// - Register 0C trim gain, user top
// - Register 0D override and framing bits
// - Override bit chooses registers over straps
// - Test select field encoding
// - Power-down pin forces global power-down
module adcscp_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hw_reset,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic serial_input_line,
    input wire logic pd_pin,
    input wire logic [1:0] output_format_strap,
    output adcscp_pkg::adcscp_ctrl_s ctrl_ff,
    output logic word_commit_ff
);

    localparam int NREG = `ADCSCP_NUM_REGS;
    localparam int DW = `ADCSCP_DATA_W;

    // Two-stage synchronisers; a third sclk stage feeds only the edge detector
    logic sclk_s1_ff;
    logic sclk_s2_ff;
    logic sclk_s3_ff;
    logic sel_s1_ff;
    logic sel_s2_ff;
    logic dat_s1_ff;
    logic dat_s2_ff;
    logic hrst_s1_ff;
    logic hrst_s2_ff;
    logic pdp_s1_ff;
    logic pdp_s2_ff;
    logic [1:0] strap_s1_ff;
    logic [1:0] strap_s2_ff;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_s3_ff <= 1'b0;
            sel_s1_ff <= 1'b1;
            sel_s2_ff <= 1'b1;
            dat_s1_ff <= 1'b0;
            dat_s2_ff <= 1'b0;
            hrst_s1_ff <= 1'b0;
            hrst_s2_ff <= 1'b0;
            pdp_s1_ff <= 1'b0;
            pdp_s2_ff <= 1'b0;
            strap_s1_ff <= 2'h0;
            strap_s2_ff <= 2'h0;
        end else begin
            sclk_s1_ff <= serial_clk;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            sel_s1_ff <= serial_select_n;
            sel_s2_ff <= sel_s1_ff;
            dat_s1_ff <= serial_input_line;
            dat_s2_ff <= dat_s1_ff;
            hrst_s1_ff <= hw_reset;
            hrst_s2_ff <= hrst_s1_ff;
            pdp_s1_ff <= pd_pin;
            pdp_s2_ff <= pdp_s1_ff;
            strap_s1_ff <= output_format_strap;
            strap_s2_ff <= strap_s1_ff;
        end
    end

    // Falling edge of the serial clock, qualified by select
    wire sclk_fall = sclk_s3_ff & ~sclk_s2_ff;
    wire sel_active = ~sel_s2_ff;
    wire shift_en = sclk_fall & sel_active;

    adcscp_pkg::adcscp_state_e state_ff;
    adcscp_pkg::adcscp_state_e nxt_state;
    logic [3:0] bit_cnt_ff;
    logic [3:0] nxt_bit_cnt;
    logic [14:0] shift_ff;
    logic [14:0] nxt_shift;

    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        case (state_ff)
            adcscp_pkg::ST_IDLE: begin
                nxt_bit_cnt = 4'h0;
                if (sel_active) begin
                    nxt_state = adcscp_pkg::ST_SHIFT;
                end
                if (shift_en) begin
                    nxt_shift = {shift_ff[13:0], dat_s2_ff};
                    nxt_bit_cnt = 4'h1;
                end
            end
            adcscp_pkg::ST_SHIFT: begin
                if (!sel_active) begin
                    // Partial word is abandoned here
                    nxt_state = adcscp_pkg::ST_IDLE;
                    nxt_bit_cnt = 4'h0;
                end else if (shift_en) begin
                    nxt_shift = {shift_ff[13:0], dat_s2_ff};
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                end
            end
            default: begin
                nxt_state = adcscp_pkg::ST_IDLE;
                nxt_bit_cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= adcscp_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 15'h0000;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
        end
    end

    // Counter wraps after the last bit, so each word starts fresh
    wire commit = shift_en & (bit_cnt_ff == `ADCSCP_LAST_BIT);
    wire [15:0] word = {shift_ff, dat_s2_ff};
    wire [4:0] wr_addr = word[15:11];
    wire [10:0] wr_data = word[10:0];

    wire sw_reset = commit & (wr_addr == `ADCSCP_OFF_PWR) & wr_data[`ADCSCP_B_SWRST];
    wire clear_all = hrst_s2_ff | sw_reset;

    // Address of each register slot
    function automatic logic [4:0] adcscp_slot_addr(input int idx);
        logic [4:0] a;
        case (idx)
            0: a = `ADCSCP_OFF_PWR;
            1: a = `ADCSCP_OFF_CLKG;
            2: a = `ADCSCP_OFF_FMT;
            3: a = `ADCSCP_OFF_USRL;
            4: a = `ADCSCP_OFF_TRIM;
            5: a = `ADCSCP_OFF_OVRD;
            6: a = `ADCSCP_OFF_DRV;
            default: a = `ADCSCP_OFF_TERM;
        endcase
        return a;
    endfunction : adcscp_slot_addr

    logic [DW-1:0] regs_ff [NREG];

    genvar gi;
    generate
        for (gi = 0; gi < NREG; gi++) begin : g_reg
            wire hit = commit & (wr_addr == adcscp_slot_addr(gi));
            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    regs_ff[gi] <= `ADCSCP_RST_VAL;
                end else if (clear_all) begin
                    // Reset bit itself is never stored, so it reads back cleared
                    regs_ff[gi] <= `ADCSCP_RST_VAL;
                end else if (hit) begin
                    regs_ff[gi] <= wr_data;
                end
            end
        end
    endgenerate

    wire [DW-1:0] r_pwr = regs_ff[0];
    wire [DW-1:0] r_clkg = regs_ff[1];
    wire [DW-1:0] r_fmt = regs_ff[2];
    wire [DW-1:0] r_usrl = regs_ff[3];
    wire [DW-1:0] r_trim = regs_ff[4];
    wire [DW-1:0] r_ovrd = regs_ff[5];
    wire [DW-1:0] r_drv = regs_ff[6];
    wire [DW-1:0] r_term = regs_ff[7];

    // Strap decode
    adcscp_pkg::adcscp_strap_e strap_lvl;
    assign strap_lvl = adcscp_pkg::adcscp_strap_e'(strap_s2_ff);
    wire strap_lsb = (strap_lvl == adcscp_pkg::STRAP_5_6) | (strap_lvl == adcscp_pkg::STRAP_FULL);
    wire strap_obin = (strap_lvl == adcscp_pkg::STRAP_3_6) | (strap_lvl == adcscp_pkg::STRAP_5_6);

    wire ovrd_en = r_ovrd[`ADCSCP_B_OV_EN];

    adcscp_pkg::adcscp_ctrl_s nxt_ctrl;
    always_comb begin
        nxt_ctrl = '0;
        nxt_ctrl.global_pd = pdp_s2_ff | r_pwr[`ADCSCP_B_PDG];
        nxt_ctrl.chan_pd = r_pwr[`ADCSCP_B_PDCH_HI:`ADCSCP_B_PDCH_LO];
        nxt_ctrl.ext_ref = r_pwr[`ADCSCP_B_REF];
        nxt_ctrl.clk_gain = r_clkg[`ADCSCP_B_CLKG_HI:`ADCSCP_B_CLKG_LO];
        nxt_ctrl.test_sel = adcscp_pkg::adcscp_test_e'(r_fmt[`ADCSCP_B_TEST_HI:`ADCSCP_B_TEST_LO]);
        nxt_ctrl.user_word = {r_trim[`ADCSCP_B_USRT], r_usrl};
        nxt_ctrl.trim_gain = r_trim[`ADCSCP_B_TRIM_HI:`ADCSCP_B_TRIM_LO];
        nxt_ctrl.drive = r_drv;
        nxt_ctrl.term = r_term;
        if (ovrd_en) begin
            nxt_ctrl.lsb_first = r_ovrd[`ADCSCP_B_OV_ORDER];
            nxt_ctrl.offset_binary = r_fmt[`ADCSCP_B_NFMT];
            nxt_ctrl.byte_wise = r_ovrd[`ADCSCP_B_OV_BYTE];
            nxt_ctrl.boost_en = r_ovrd[`ADCSCP_B_OV_BOOST];
            nxt_ctrl.rise_capture = r_ovrd[`ADCSCP_B_OV_EDGE];
            nxt_ctrl.frame14 = r_ovrd[`ADCSCP_B_OV_FRAME];
            nxt_ctrl.sdr_clk = r_ovrd[`ADCSCP_B_OV_DDR];
            nxt_ctrl.two_wire = r_ovrd[`ADCSCP_B_OV_WIRE];
        end else begin
            // Other strapped modes live outside this block; they show as zero here
            nxt_ctrl.lsb_first = strap_lsb;
            nxt_ctrl.offset_binary = strap_obin;
        end
    end

    // One register stage keeps the effect inside the settle time, which it can reach at four cycles
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_ff <= '0;
            word_commit_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            word_commit_ff <= commit;
        end
    end

    // No drive on the serial data line: the port is write-only

endmodule : adcscp_top

/* File: adcscp_top_props.sv */
`timescale 1ns/1ps
module adcscp_top_props (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hw_reset,
    input wire logic serial_clk,
    input wire logic serial_select_n,
    input wire logic pd_pin,
    input adcscp_pkg::adcscp_ctrl_s ctrl_ff,
    input wire logic word_commit_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    commit_gap_a: assert property (word_commit_ff |=> !word_commit_ff [*8])
        else $error("commit too long");
    commit_sel_a: assert property (word_commit_ff |-> !$past(serial_select_n, 3))
        else $error("commit without select");
    commit_clk_a: assert property (word_commit_ff |-> !$past(serial_clk, 2))
        else $error("commit without clock fall");
    sel_idle_a: assert property (serial_select_n [*8] |-> !word_commit_ff)
        else $error("commit while idle");
    // Hardware reset needs up to four cycles to land, hence the quiet window
    // The commit pulse leads the control word by one cycle
    quiet_regs_a: assert property (!hw_reset [*6] ##0 $changed({ctrl_ff.clk_gain, ctrl_ff.user_word})
        |-> $past(word_commit_ff)) else $error("change without commit");
    pd_force_a: assert property (pd_pin [*5] |-> ctrl_ff.global_pd)
        else $error("pd pin ignored");
    pd_src_a: assert property ($rose(ctrl_ff.global_pd) |-> $past(pd_pin, 2) || $past(pd_pin, 3) || $past(word_commit_ff))
        else $error("power-down without cause");
    hw_clear_a: assert property (hw_reset [*5] |=> ctrl_ff.user_word == 12'h000 && ctrl_ff.clk_gain == 5'h00)
        else $error("hardware reset left state");
endmodule : adcscp_top_props

/* File: adcscp_host.sv */
`timescale 1ns/1ps
module adcscp_host (
    output logic serial_clk,
    output logic serial_select_n,
    output logic serial_input_line
);
    initial begin
        serial_clk = 1'b1;
        serial_select_n = 1'b1;
        serial_input_line = 1'b0;
    end
    // Clock parks high between frames; data idles inverted since nothing holds it
    task automatic frame(input logic [47:0] b, input int n, input int half);
        #13;
        serial_select_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_input_line = b[i];
            #(half);
            serial_clk = 1'b0;
            #(half);
            serial_clk = 1'b1;
        end
        #(half);
        serial_select_n = 1'b1;
        serial_input_line = ~serial_input_line;
        // Deselect must last a few system cycles or a partial word is never dropped
        #(half);
    endtask : frame
endmodule : adcscp_host

/* File: adcscp_top_tb.sv */
`timescale 1ns/1ps
module adcscp_top_tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_reset = 1'b0;
    logic pd_pin = 1'b0;
    logic [1:0] strap = 2'h0;
    wire sclk;
    wire sel_n;
    wire sdi;
    adcscp_pkg::adcscp_ctrl_s ctrl_ff;
    logic word_commit_ff;
    logic cmt_d = 1'b0;
    adcscp_pkg::adcscp_ctrl_s q[$];
    logic [10:0] r [32];
    logic [4:0] adr [8] = '{5'h00, 5'h04, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h10, 5'h11};
    logic [10:0] msk [8] = '{11'h03F, 11'h07C, 11'h2E0, 11'h7FF, 11'h701, 11'h4F7, 11'h7FF, 11'h7FF};
    logic [31:0] seed = 32'h00000025;
    int n_fail = 0;
    int n_checks = 0;
    adcscp_host adcscp_host_i (.serial_clk(sclk), .serial_select_n(sel_n), .serial_input_line(sdi));
    // Reserved strap is grounded off-block and has no pin here
    adcscp_top adcscp_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .hw_reset(hw_reset), .serial_clk(sclk),
        .serial_select_n(sel_n), .serial_input_line(sdi), .pd_pin(pd_pin), .output_format_strap(strap),
        .ctrl_ff(ctrl_ff), .word_commit_ff(word_commit_ff));
    always #12.5 ref_clk = ~ref_clk;
    function automatic logic [10:0] rnd(input logic [10:0] m);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[10:0] & m;
    endfunction : rnd
    function automatic adcscp_pkg::adcscp_ctrl_s exc();
        adcscp_pkg::adcscp_ctrl_s c;
        logic [10:0] o;
        c = '0;
        o = r[13];
        c.global_pd = pd_pin | r[0][0];
        c.chan_pd = r[0][4:1];
        c.ext_ref = r[0][5];
        c.clk_gain = r[4][6:2];
        c.test_sel = adcscp_pkg::adcscp_test_e'(r[10][7:5]);
        c.user_word = {r[12][0], r[11]};
        c.trim_gain = r[12][10:8];
        c.drive = r[16];
        c.term = r[17];
        c.lsb_first = o[10] ? o[6] : strap[1];
        c.offset_binary = o[10] ? r[10][9] : strap[1] ^ strap[0];
        if (o[10]) begin
            {c.byte_wise, c.boost_en, c.rise_capture, c.frame14, c.sdr_clk, c.two_wire} = {o[7], o[5:4], o[2:0]};
        end
        return c;
    endfunction : exc
    task automatic chk(input string nm, input adcscp_pkg::adcscp_ctrl_s e);
        n_checks++;
        if (ctrl_ff !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, ctrl_ff);
        end
    endtask : chk
    task automatic put(input logic [4:0] a, input logic [10:0] d);
        if (a == 5'h00 && d[10]) r = '{default: 11'h000};
        else r[a] = d;
        q.push_back(exc());
    endtask : put
    task automatic wr(input logic [4:0] a, input logic [10:0] d, input int half);
        put(a, d);
        adcscp_host_i.frame({32'h0, a, d}, 16, half);
    endtask : wr
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask : tick
    task automatic end_sim();
        if (n_fail == 0 && n_checks > 0 && q.size() == 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // The pulse leads the control word by one cycle, so compare a cycle later
    always @(posedge ref_clk) cmt_d <= word_commit_ff;
    // A commit with no note left compares against a value that cannot match
    always @(negedge ref_clk) begin
        if (cmt_d === 1'b1) begin
            chk("ctrl_ff", q.size() > 0 ? q.pop_front() : ~exc());
        end
    end
    initial begin
        logic [10:0] d1;
        logic [10:0] d2;
        r = '{default: 11'h000};
        tick(16);
        rst_n = 1'b1;
        tick(4);
        hw_reset = 1'b1;
        tick(3);
        hw_reset = 1'b0;
        tick(4);
        chk("reset", exc());
        foreach (adr[i]) wr(adr[i], rnd(msk[i]), 100);
        wr(5'h1F, rnd(11'h7FF), 100);
        for (int t = 0; t < 8; t++) wr(5'h0A, 11'(t) << 5, 100);
        d1 = rnd(11'h701);
        d2 = 11'h400 | rnd(11'h0F7);
        put(5'h0C, d1);
        put(5'h0D, d2);
        adcscp_host_i.frame({1'b0, 5'h0C, d1, 5'h0D, d2, 15'h7FFF}, 47, 100);
        wr(5'h0D, 11'h000, 100);
        for (int s = 0; s < 4; s++) begin
            strap = 2'(s);
            tick(6);
            chk("strap", exc());
        end
        pd_pin = 1'b1;
        tick(6);
        chk("pd_pin", exc());
        pd_pin = 1'b0;
        adcscp_host_i.frame(48'h7F, 7, 100);
        wr(5'h04, rnd(11'h07C), 150);
        wr(5'h00, 11'h400 | rnd(11'h03F), 100);
        wr(5'h0B, rnd(11'h7FF) | 11'h001, 100);
        hw_reset = 1'b1;
        tick(8);
        hw_reset = 1'b0;
        r = '{default: 11'h000};
        tick(4);
        chk("hw_reset", exc());
        wr(5'h10, rnd(11'h7FF), 100);
        tick(8);
        end_sim();
    end
    // About two dozen frames of 3.5 us each, with wide margin
    initial begin
        #400us;
        n_fail++;
        end_sim();
    end
endmodule : adcscp_top_tb
bind adcscp_top adcscp_top_props adcscp_top_props_i (.ref_clk(ref_clk), .rst_n(rst_n), .hw_reset(hw_reset),
    .serial_clk(serial_clk), .serial_select_n(serial_select_n), .pd_pin(pd_pin), .ctrl_ff(ctrl_ff),
    .word_commit_ff(word_commit_ff));
